// *** ios_pkg.sv ***
// Shared constants, object indices and types for the I/O sync module link
package ios_pkg;

  // ---------------------------------------------------------------
  // Object word and object indices
  // ---------------------------------------------------------------
  localparam int OBJ_W = 16;
  typedef logic [OBJ_W-1:0] ios_word_t;

  localparam ios_word_t IDX_CAPS       = 16'h0005;
  localparam ios_word_t IDX_SUBST_MODE = 16'h0024;
  localparam ios_word_t IDX_SUBST_DATA = 16'h002F;
  localparam ios_word_t IDX_SYNC_EN    = 16'h0030;
  localparam ios_word_t IDX_SYNC_POINT = 16'h0031;
  localparam ios_word_t IDX_TM_REPEAT  = 16'h0032;
  localparam ios_word_t IDX_TM_PROC    = 16'h0033;
  localparam ios_word_t IDX_TM_RUNUP   = 16'h0034;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int CAP_IN_BIT  = 0;
  localparam int CAP_OUT_BIT = 1;
  localparam int SYNC_EN_BIT = 0;

  localparam ios_word_t SUBST_ZERO  = 16'h0000;
  localparam ios_word_t SUBST_FINAL = 16'h0001;
  localparam ios_word_t SUBST_HOLD  = 16'h0002;
  localparam ios_word_t SUBST_USER  = 16'h0003;

  // ---------------------------------------------------------------
  // Reset values and final substitute value
  // ---------------------------------------------------------------
  localparam ios_word_t RST_SUBST_MODE = 16'h0000;
  localparam ios_word_t RST_SUBST_DATA = 16'h0000;
  localparam ios_word_t RST_SYNC_POINT = 16'h0000;
  localparam ios_word_t PWRON_VALUE    = 16'h0000;
  localparam ios_word_t FINAL_VALUE    = 16'hFFFF;

  // ---------------------------------------------------------------
  // Times and cycle counts (clock 10 MHz)
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int CYCLE_NS      = 10000;
  localparam int MIN_REPEAT_NS = 2000;
  localparam int PROC_BASE_NS  = 500;
  localparam int RUNUP_NS      = 300;
  localparam int CYC_PERIOD    = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam ios_word_t MIN_REPEAT_CYC = 16'((MIN_REPEAT_NS + CLK_NS - 1) / CLK_NS);
  localparam ios_word_t PROC_BASE_CYC  = 16'((PROC_BASE_NS + CLK_NS - 1) / CLK_NS);
  localparam ios_word_t RUNUP_CYC      = 16'((RUNUP_NS + CLK_NS - 1) / CLK_NS);
  localparam int MISS_CYCLES   = 3;
  localparam int INIT_STEPS    = 8;

  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IOS_ST_PWRON = 2'b00,
    IOS_ST_RUN   = 2'b01,
    IOS_ST_SUBST = 2'b10
  } ios_dev_state_t;

  typedef enum logic [1:0] {
    IOS_HS_INIT = 2'b00,
    IOS_HS_WAIT = 2'b01,
    IOS_HS_RUN  = 2'b10
  } ios_head_state_t;

endpackage

// *** ios_if.sv ***
// Local bus link between head station and I/O module
`timescale 1ns/1ns
interface ios_if;
  import ios_pkg::*;

  logic      cyc;
  ios_word_t pd_out;
  logic      pd_out_valid;
  ios_word_t pd_in;
  logic      obj_req;
  logic      obj_we;
  ios_word_t obj_idx;
  ios_word_t obj_wdata;
  ios_word_t obj_rdata;
  logic      obj_ack;

  modport dev (
    input  cyc, pd_out, pd_out_valid, obj_req, obj_we, obj_idx, obj_wdata,
    output pd_in, obj_rdata, obj_ack
  );

  modport head (
    output cyc, pd_out, pd_out_valid, obj_req, obj_we, obj_idx, obj_wdata,
    input  pd_in, obj_rdata, obj_ack
  );
endinterface

// *** ios_watchdog.sv ***
// Missing process data detector counting bus cycles without update
`timescale 1ns/1ns
module ios_watchdog #(
  parameter int LIMIT = ios_pkg::MISS_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic armed_in,
  input  wire logic cyc_in,
  input  wire logic valid_in,
  output logic      expired_out
);
  import ios_pkg::*;

  logic [7:0] miss_reg;

  // A valid update restarts the count even in the cycle it would expire
  always_ff @(posedge clk_in) begin
    if (srst_in || !armed_in || valid_in) begin
      miss_reg    <= 8'h00;
      expired_out <= 1'b0;
    end else if (cyc_in && !expired_out) begin
      miss_reg    <= miss_reg + 8'h01;
      expired_out <= (miss_reg + 8'h01) >= 8'(LIMIT);
    end
  end
endmodule // ios_watchdog

// *** ios_device.sv ***
// I/O module end: sync timing, consistent process data and substitute values
// What this block does
// - Capability object shows input/output sync flags
// - Async mode acts at the network cycle strobe
// - All data of one module taken together
// - Report repeat, processing and run-up times
// - Times fixed or derived from current settings
// - Head reads times, forwards to clock master
// - Head writes sync point; module acts there
// - Unsynchronisable module works as fast as possible
// - Sync mode can be switched off
// - Head enables sync only when all support
// - Power-on outputs hold until first valid data
// - Substitute watch armed after first valid data
// - Missing data switches outputs to substitute
// - Modes zero, final value, hold last
// - Mode three drives user substitute object
// - Local bus cycle aligned to network cycle
`timescale 1ns/1ns
module ios_device #(
  parameter bit IN_SYNC_CAP  = 1'b1,
  parameter bit OUT_SYNC_CAP = 1'b1,
  parameter int MISS_LIMIT   = ios_pkg::MISS_CYCLES
) (
  input  wire logic               clk_in,
  input  wire logic               srst_in,
  ios_if.dev                      bus,
  input  wire ios_pkg::ios_word_t field_in,
  output ios_pkg::ios_word_t      field_out,
  output ios_pkg::ios_dev_state_t state_out,
  output logic                    sync_active_out
);
  import ios_pkg::*;

  // ---------------------------------------------------------------
  // Configuration objects
  // ---------------------------------------------------------------
  ios_word_t      subst_mode_reg;
  ios_word_t      subst_data_reg;
  ios_word_t      sync_point_reg;
  logic           sync_en_reg;
  ios_word_t      rdata_reg;
  logic           ack_reg;
  ios_word_t      rx_reg;
  ios_word_t      rx_next;
  ios_word_t      in_reg;
  ios_word_t      delay_reg;
  logic           pending_reg;
  logic           fire;
  logic           out_evt;
  logic           in_evt;
  logic           expired;
  ios_word_t      subst_val;
  ios_word_t      caps;
  ios_word_t      tm_proc;
  ios_dev_state_t state_reg;

  assign caps = {14'h0000, OUT_SYNC_CAP, IN_SYNC_CAP};

  // Processing duration grows with the chosen sync point
  assign tm_proc = sync_en_reg ? PROC_BASE_CYC + sync_point_reg
                               : PROC_BASE_CYC;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      subst_mode_reg <= RST_SUBST_MODE;
      subst_data_reg <= RST_SUBST_DATA;
      sync_point_reg <= RST_SYNC_POINT;
      sync_en_reg    <= 1'b0;
    end else if (bus.obj_req && bus.obj_we) begin
      case (bus.obj_idx)
        IDX_SUBST_MODE: begin
          subst_mode_reg <= bus.obj_wdata;
        end
        IDX_SUBST_DATA: begin
          subst_data_reg <= bus.obj_wdata;
        end
        IDX_SYNC_POINT: begin
          sync_point_reg <= bus.obj_wdata;
        end
        IDX_SYNC_EN: begin
          // A module without sync capability never leaves async mode
          sync_en_reg <= bus.obj_wdata[SYNC_EN_BIT] & (IN_SYNC_CAP | OUT_SYNC_CAP);
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Object read answer, one cycle after the request
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= bus.obj_req;
      if (bus.obj_req && !bus.obj_we) begin
        case (bus.obj_idx)
          IDX_CAPS: begin
            rdata_reg <= caps;
          end
          IDX_SUBST_MODE: begin
            rdata_reg <= subst_mode_reg;
          end
          IDX_SUBST_DATA: begin
            rdata_reg <= subst_data_reg;
          end
          IDX_SYNC_EN: begin
            rdata_reg <= {15'h0000, sync_en_reg};
          end
          IDX_SYNC_POINT: begin
            rdata_reg <= sync_point_reg;
          end
          IDX_TM_REPEAT: begin
            rdata_reg <= MIN_REPEAT_CYC;
          end
          IDX_TM_PROC: begin
            rdata_reg <= tm_proc;
          end
          IDX_TM_RUNUP: begin
            rdata_reg <= RUNUP_CYC;
          end
          default: begin
            rdata_reg <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign bus.obj_ack   = ack_reg;
  assign bus.obj_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // Sync point timer, started by each bus cycle strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      delay_reg   <= 16'h0000;
      pending_reg <= 1'b0;
    end else if (bus.cyc && sync_en_reg) begin
      delay_reg   <= sync_point_reg;
      pending_reg <= 1'b1;
    end else if (pending_reg) begin
      delay_reg   <= delay_reg - 16'h0001;
      pending_reg <= (delay_reg != 16'h0000);
    end
  end

  assign fire = pending_reg && (delay_reg == 16'h0000);

  // Capable modules act at the strobe or sync point; others at once
  assign out_evt = OUT_SYNC_CAP ? (sync_en_reg ? fire : bus.cyc)
                                : bus.pd_out_valid;
  assign in_evt  = IN_SYNC_CAP ? (sync_en_reg ? fire : bus.cyc)
                               : 1'b1;

  // ---------------------------------------------------------------
  // Process data, latched whole so words never mix cycles
  // ---------------------------------------------------------------
  assign rx_next = bus.pd_out_valid ? bus.pd_out : rx_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_reg <= PWRON_VALUE;
    end else begin
      rx_reg <= rx_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      in_reg <= 16'h0000;
    end else if (in_evt) begin
      in_reg <= field_in;
    end
  end

  assign bus.pd_in = in_reg;

  // ---------------------------------------------------------------
  // Power-on, run and substitute behaviour
  // ---------------------------------------------------------------
  ios_watchdog #(
    .LIMIT       (MISS_LIMIT)
  ) u_watchdog (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .armed_in    (state_reg == IOS_ST_RUN),
    .cyc_in      (bus.cyc),
    .valid_in    (bus.pd_out_valid),
    .expired_out (expired)
  );

  always_comb begin
    case (subst_mode_reg)
      SUBST_ZERO: begin
        subst_val = 16'h0000;
      end
      SUBST_FINAL: begin
        subst_val = FINAL_VALUE;
      end
      SUBST_USER: begin
        subst_val = subst_data_reg;
      end
      default: begin
        subst_val = field_out;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= IOS_ST_PWRON;
    end else if (bus.pd_out_valid) begin
      state_reg <= IOS_ST_RUN;
    end else if (state_reg == IOS_ST_RUN && expired) begin
      state_reg <= IOS_ST_SUBST;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      field_out <= PWRON_VALUE;
    end else if (state_reg == IOS_ST_RUN && expired && !bus.pd_out_valid) begin
      field_out <= subst_val;
    end else if (out_evt && (state_reg != IOS_ST_PWRON || bus.pd_out_valid)) begin
      // Substitute refreshes so a mode change lands; a fresh frame beats it
      field_out <= (state_reg == IOS_ST_SUBST && !bus.pd_out_valid) ? subst_val : rx_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_out       <= IOS_ST_PWRON;
      sync_active_out <= 1'b0;
    end else begin
      state_out       <= state_reg;
      sync_active_out <= sync_en_reg;
    end
  end
endmodule // ios_device

// *** ios_head.sv ***
// Head station end: configures the module, reads times, drives cycles
`timescale 1ns/1ns
module ios_head #(
  parameter int CYC_LEN = ios_pkg::CYC_PERIOD
) (
  input  wire logic               clk_in,
  input  wire logic               srst_in,
  ios_if.head                     bus,
  input  wire logic               link_ok_in,
  input  wire logic               sync_req_in,
  input  wire logic               net_sync_ok_in,
  input  wire ios_pkg::ios_word_t sync_point_in,
  input  wire ios_pkg::ios_word_t subst_mode_in,
  input  wire ios_pkg::ios_word_t subst_data_in,
  input  wire ios_pkg::ios_word_t pd_out_in,
  output ios_pkg::ios_word_t      pd_in_out,
  output logic [1:0]              caps_out,
  output ios_pkg::ios_word_t      tm_repeat_out,
  output ios_pkg::ios_word_t      tm_proc_out,
  output ios_pkg::ios_word_t      tm_runup_out,
  output logic                    ready_out
);
  import ios_pkg::*;

  // ---------------------------------------------------------------
  // Start-up sequence
  // ---------------------------------------------------------------
  function automatic ios_word_t step_idx(input logic [2:0] s);
    case (s)
      3'h0:    step_idx = IDX_CAPS;
      3'h1:    step_idx = IDX_TM_REPEAT;
      3'h2:    step_idx = IDX_TM_PROC;
      3'h3:    step_idx = IDX_TM_RUNUP;
      3'h4:    step_idx = IDX_SUBST_MODE;
      3'h5:    step_idx = IDX_SUBST_DATA;
      3'h6:    step_idx = IDX_SYNC_POINT;
      default: step_idx = IDX_SYNC_EN;
    endcase
  endfunction

  ios_head_state_t st_reg;
  logic [2:0]      step_reg;
  logic [15:0]     cnt_reg;
  logic            req_reg;
  logic            we_reg;
  ios_word_t       idx_reg;
  ios_word_t       wdata_reg;
  logic            cyc_reg;
  logic            valid_reg;
  ios_word_t       pd_reg;
  ios_word_t       wval;

  // Sync only when network, head and module all agree
  always_comb begin
    case (step_reg)
      3'h4:    wval = subst_mode_in;
      3'h5:    wval = subst_data_in;
      3'h6:    wval = sync_point_in;
      default: wval = {15'h0000, sync_req_in & net_sync_ok_in & (|caps_out)};
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg        <= IOS_HS_INIT;
      step_reg      <= 3'h0;
      req_reg       <= 1'b0;
      we_reg        <= 1'b0;
      idx_reg       <= 16'h0000;
      wdata_reg     <= 16'h0000;
      caps_out      <= 2'h0;
      tm_repeat_out <= 16'h0000;
      tm_proc_out   <= 16'h0000;
      tm_runup_out  <= 16'h0000;
      ready_out     <= 1'b0;
    end else begin
      req_reg <= 1'b0;
      case (st_reg)
        IOS_HS_INIT: begin
          req_reg   <= 1'b1;
          we_reg    <= step_reg >= 3'h4;
          idx_reg   <= step_idx(step_reg);
          wdata_reg <= wval;
          st_reg    <= IOS_HS_WAIT;
        end
        IOS_HS_WAIT: begin
          if (bus.obj_ack) begin
            case (step_reg)
              3'h0:    caps_out      <= bus.obj_rdata[1:0];
              3'h1:    tm_repeat_out <= bus.obj_rdata;
              3'h2:    tm_proc_out   <= bus.obj_rdata;
              3'h3:    tm_runup_out  <= bus.obj_rdata;
              default: begin
              end
            endcase
            step_reg  <= step_reg + 3'h1;
            st_reg    <= (step_reg == 3'(INIT_STEPS - 1)) ? IOS_HS_RUN : IOS_HS_INIT;
            ready_out <= (step_reg == 3'(INIT_STEPS - 1));
          end
        end
        IOS_HS_RUN: begin
          ready_out <= 1'b1;
        end
        default: begin
          st_reg <= IOS_HS_INIT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle strobe and cyclic process data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_reg   <= 16'h0000;
      cyc_reg   <= 1'b0;
      valid_reg <= 1'b0;
      pd_reg    <= 16'h0000;
      pd_in_out <= 16'h0000;
    end else begin
      cyc_reg   <= (cnt_reg == 16'(CYC_LEN - 1));
      cnt_reg   <= (cnt_reg == 16'(CYC_LEN - 1)) ? 16'h0000 : cnt_reg + 16'h0001;
      // Broken link is modelled by withholding valid data
      valid_reg <= (cnt_reg == 16'(CYC_LEN - 1)) && ready_out && link_ok_in;
      if (cnt_reg == 16'(CYC_LEN - 1)) begin
        pd_reg    <= pd_out_in;
        pd_in_out <= bus.pd_in;
      end
    end
  end

  assign bus.cyc          = cyc_reg;
  assign bus.pd_out       = pd_reg;
  assign bus.pd_out_valid = valid_reg;
  assign bus.obj_req      = req_reg;
  assign bus.obj_we       = we_reg;
  assign bus.obj_idx      = idx_reg;
  assign bus.obj_wdata    = wdata_reg;
endmodule // ios_head

// *** ios_properties.sv ***
// Checker on the link between head station and I/O module
`timescale 1ns/1ns
module ios_properties #(
  parameter int CYC_LEN = ios_pkg::CYC_PERIOD
) (
  input wire logic               clk_in,
  input wire logic               srst_in,
  input wire logic               cyc,
  input wire ios_pkg::ios_word_t pd_out,
  input wire logic               pd_out_valid,
  input wire ios_pkg::ios_word_t pd_in,
  input wire logic               obj_req,
  input wire logic               obj_we,
  input wire ios_pkg::ios_word_t obj_idx,
  input wire ios_pkg::ios_word_t obj_wdata,
  input wire ios_pkg::ios_word_t obj_rdata,
  input wire logic               obj_ack
);
  import ios_pkg::*;

  // ---------------------------------------------------------------
  // Helper state
  // ---------------------------------------------------------------
  logic [15:0] gap_reg;
  logic        gap_seen_reg;
  logic        any_req_reg;
  logic        sp_written_reg;

  // First strobe after reset has no reference, so the gap check waits
  always_ff @(posedge clk_in) begin
    if (srst_in || cyc) begin
      gap_reg <= 16'h0000;
    end else begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      gap_seen_reg <= 1'b0;
    end else if (cyc) begin
      gap_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      any_req_reg <= 1'b0;
    end else if (obj_req) begin
      any_req_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sp_written_reg <= 1'b0;
    end else if (obj_req && obj_we && obj_idx == IDX_SYNC_POINT) begin
      sp_written_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  ack_timing_a: assert property (obj_req |=> obj_ack)
    else $error("object request not answered one cycle later");
  ack_cause_a: assert property (obj_ack |-> $past(obj_req))
    else $error("object answer without request");
  ack_single_a: assert property (obj_ack |=> !obj_ack)
    else $error("object answer longer than one cycle");
  req_spacing_a: assert property (obj_req |=> !obj_req)
    else $error("object requests too close");
  first_read_caps_a: assert property (obj_req && !any_req_reg |->
    !obj_we && obj_idx == IDX_CAPS)
    else $error("start-up does not begin with capability read");
  caps_flags_a: assert property (obj_req && !obj_we && obj_idx == IDX_CAPS
    |=> obj_rdata[CAP_OUT_BIT:CAP_IN_BIT] == 2'b11)
    else $error("capability flags missing");
  repeat_time_a: assert property (obj_req && !obj_we && obj_idx == IDX_TM_REPEAT
    |=> obj_rdata == MIN_REPEAT_CYC)
    else $error("wrong minimum repeat time");
  runup_time_a: assert property (obj_req && !obj_we && obj_idx == IDX_TM_RUNUP
    |=> obj_rdata == RUNUP_CYC)
    else $error("wrong run-up time");
  sp_before_en_a: assert property (obj_req && obj_we && obj_idx == IDX_SYNC_EN
    |-> sp_written_reg)
    else $error("sync enabled before sync point written");
  valid_in_cycle_a: assert property (pd_out_valid |-> cyc)
    else $error("process data outside bus cycle");
  cyc_period_a: assert property (cyc && gap_seen_reg |-> gap_reg == CYC_LEN - 1)
    else $error("bus cycle period wrong");
  pd_hold_a: assert property (!cyc |-> $stable(pd_out))
    else $error("process data changed between bus cycles");

  cover property (pd_out_valid);
  cover property (cyc && !pd_out_valid);
  cover property (obj_req && obj_we && obj_idx == IDX_SYNC_EN);
  cover property (obj_req && obj_we && obj_idx == IDX_SUBST_MODE);
endmodule // ios_properties

// *** tb_io_module_sync_and_substitute.sv ***
// Self-checking bench joining head station and I/O module ends
`timescale 1ns/1ns
module tb_io_module_sync_and_substitute;
  import ios_pkg::*;
  localparam int CYC = 10;

  logic           clk_in = 1'b0;
  logic           srst_in = 1'b1;
  logic           link_ok = 1'b0;
  logic           sync_req = 1'b0;
  logic           net_ok = 1'b0;
  ios_word_t      sync_point = 16'h0000;
  ios_word_t      subst_mode = 16'h0000;
  ios_word_t      subst_data = 16'hA5A5;
  ios_word_t      pd_val = 16'h1234;
  ios_word_t      field_in = 16'h0000;
  ios_word_t      pd_in_out;
  logic [1:0]     caps;
  ios_word_t      tm_repeat;
  ios_word_t      tm_proc;
  ios_word_t      tm_runup;
  logic           ready;
  ios_word_t      field_out;
  ios_dev_state_t state_out;
  logic           sync_active;
  int             failures = 0;
  int             n_checks = 0;
  ios_word_t      modes [5] = '{SUBST_ZERO, SUBST_FINAL, SUBST_HOLD, SUBST_USER, 16'h0005};
  ios_word_t      exps [5] = '{16'h0000, FINAL_VALUE, 16'h1234, 16'hA5A5, 16'h1234};

  always #50 clk_in = ~clk_in;

  ios_if u_ios_if();

  ios_head #(.CYC_LEN(CYC)) u_ios_head (
    .clk_in(clk_in), .srst_in(srst_in), .bus(u_ios_if), .link_ok_in(link_ok),
    .sync_req_in(sync_req), .net_sync_ok_in(net_ok), .sync_point_in(sync_point),
    .subst_mode_in(subst_mode), .subst_data_in(subst_data), .pd_out_in(pd_val),
    .pd_in_out(pd_in_out), .caps_out(caps), .tm_repeat_out(tm_repeat),
    .tm_proc_out(tm_proc), .tm_runup_out(tm_runup), .ready_out(ready)
  );

  ios_device #(.MISS_LIMIT(MISS_CYCLES)) u_ios_device (
    .clk_in(clk_in), .srst_in(srst_in), .bus(u_ios_if), .field_in(field_in),
    .field_out(field_out), .state_out(state_out), .sync_active_out(sync_active)
  );

  ios_properties #(.CYC_LEN(CYC)) u_ios_properties (
    .clk_in(clk_in), .srst_in(srst_in), .cyc(u_ios_if.cyc), .pd_out(u_ios_if.pd_out),
    .pd_out_valid(u_ios_if.pd_out_valid), .pd_in(u_ios_if.pd_in),
    .obj_req(u_ios_if.obj_req), .obj_we(u_ios_if.obj_we), .obj_idx(u_ios_if.obj_idx),
    .obj_wdata(u_ios_if.obj_wdata), .obj_rdata(u_ios_if.obj_rdata),
    .obj_ack(u_ios_if.obj_ack)
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input ios_word_t got, input ios_word_t exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Samples one time unit after the edge so the edge's updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Start-up values are only sampled during start-up, so each mode needs a reset
  task automatic start(input ios_word_t mode, input logic sreq, input logic sok);
    int k;
    k = 0;
    @(posedge clk_in);
    srst_in <= 1'b1;
    link_ok <= 1'b0;
    subst_mode <= mode;
    sync_req <= sreq;
    net_ok <= sok;
    sync_point <= 16'h0004;
    pd_val <= 16'h1234;
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    while (ready !== 1'b1 && k < 200) begin
      wait_cyc(1);
      k++;
    end
    check(16'(ready), 16'h0001, "start-up done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 5; i++) begin
      start(modes[i], i >= 3, i == 3);
      check(16'(caps), 16'h0003, "capabilities");
      check(tm_repeat, MIN_REPEAT_CYC, "repeat time");
      check(tm_runup, RUNUP_CYC, "run-up time");
      // Times are read before sync is switched on, so the base value shows
      check(tm_proc, PROC_BASE_CYC, "processing time");
      check(16'(sync_active), 16'(i == 3), "sync enable");
      wait_cyc(2 * CYC);
      check(field_out, PWRON_VALUE, "power-on output");
      check(16'(state_out), 16'(IOS_ST_PWRON), "power-on state");
      @(posedge clk_in);
      link_ok <= 1'b1;
      field_in <= 16'h5A00 + 16'(i);
      wait_cyc(3 * CYC);
      check(field_out, 16'h1234, "output data");
      check(pd_in_out, 16'h5A00 + 16'(i), "input data");
      check(16'(state_out), 16'(IOS_ST_RUN), "run state");
      @(posedge clk_in);
      link_ok <= 1'b0;
      pd_val <= 16'h4321;
      wait_cyc((MISS_CYCLES - 1) * CYC);
      check(16'(state_out), 16'(IOS_ST_RUN), "early substitute");
      wait_cyc(3 * CYC);
      check(field_out, exps[i], "substitute output");
      check(16'(state_out), 16'(IOS_ST_SUBST), "substitute state");
      @(posedge clk_in);
      link_ok <= 1'b1;
      wait_cyc(3 * CYC);
      check(field_out, 16'h4321, "recovered output");
      check(16'(state_out), 16'(IOS_ST_RUN), "recovered state");
      $display("test %0d done, substitute code %h", i, modes[i]);
    end
    end_of_test();
  end

  // Five runs of about 160 cycles each; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule // tb_io_module_sync_and_substitute
